// *** hdl/trace_pkg.sv ***
// Constants, register map and state encodings for the trace pointer register bank.
// Assumes a local RAM of MEM_WORDS 32-bit words organised as 128-bit entries.
package trace_pkg;
  localparam int MEM_WORDS = 256;
  localparam int ENTRY_WORDS = 4;
  localparam int ENTRY_BYTES = 16;
  localparam int ENTRY_SHIFT = $clog2(ENTRY_BYTES);
  localparam int PTR_W = $clog2(MEM_WORDS * 4);
  localparam int TRG_W = $clog2(MEM_WORDS);
  localparam int DEPTH = MEM_WORDS / ENTRY_WORDS;
  localparam int AW = $clog2(DEPTH);
  localparam int UP_W = 8;
  // Register byte offsets on the APB slave port.
  localparam logic [11:0] OFS_STATUS = 12'h00c;
  localparam logic [11:0] OFS_RD_DATA = 12'h010;
  localparam logic [11:0] OFS_RPTR = 12'h014;
  localparam logic [11:0] OFS_WPTR = 12'h018;
  localparam logic [11:0] OFS_TRG = 12'h01c;
  localparam logic [11:0] OFS_CTRL = 12'h020;
  localparam logic [11:0] OFS_WR_DATA = 12'h024;
  localparam logic [11:0] OFS_MODE = 12'h028;
  localparam logic [11:0] OFS_RPTR_UP = 12'h038;
  localparam logic [11:0] OFS_WPTR_UP = 12'h03c;
  // Field positions.
  localparam int CTRL_EN_BIT = 0;
  localparam int STS_FULL = 0;
  localparam int STS_TRIGGERED = 1;
  localparam int STS_READY = 2;
  localparam int STS_MEMORY_ERROR_FLAG = 5;
  // Reset values and fixed codes.
  localparam logic [PTR_W-1:0] PTR_RST = 10'h000;
  localparam logic [TRG_W-1:0] TRG_RST = 8'h00;
  localparam logic [6:0] TRIG_ID = 7'h7d;
  localparam logic [31:0] NO_DATA = 32'hffffffff;
  typedef enum logic [1:0] {
    MODE_CIRC = 2'h0,
    MODE_SWFIFO = 2'h1,
    MODE_HWFIFO = 2'h2
  } mode_e;
  typedef enum logic [1:0] {
    ST_DISABLED = 2'h0,
    ST_RUNNING = 2'h1,
    ST_STOPPING = 2'h3,
    ST_STOPPED = 2'h2
  } state_e;
endpackage

// *** hdl/trace_ram.sv ***
// Trace memory of full-width entries with one write port and a registered read port.
// Assumes write and read addresses come from the same clock domain.
`timescale 1ns/1ps
module trace_ram (
  input wire logic mclk,
  input wire logic we,
  input wire logic [trace_pkg::AW-1:0] waddr,
  input wire logic [trace_pkg::ENTRY_WORDS*32-1:0] wdata,
  input wire logic [trace_pkg::AW-1:0] raddr,
  output logic [trace_pkg::ENTRY_WORDS*32-1:0] rdata
);
  logic [trace_pkg::ENTRY_WORDS*32-1:0] mem [trace_pkg::DEPTH];

  // Stores an entry and registers the addressed entry every cycle.
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// *** hdl/trace_ptr_regs.sv ***
// Pointer, trigger counter and control registers of a trace capture buffer.
// Assumes an APB slave with zero wait states and a formatter on the same clock.
// How it works
// - Full entry read advances read pointer.
// - Pointer width is log2 of four times words.
// - Read pointer holds trace address, not tables.
// - Read pointer written only while disabled.
// - Pointers readable in the listed states.
// - Entering disabled in circular mode, read pointer marks oldest data.
// - Write pointer written only while disabled.
// - Write pointer reads as next target.
// - Full entry written advances write pointer.
// - Write pointer wrap sets full flag.
// - Circular keeps write pointer, else returns home.
// - Pin edge or trigger packet starts count.
// - Count plus one words follow trigger.
// - Counter ignored in both FIFO modes.
// - Counting ignores triggers; zero holds until rewrite.
// - Counter cleared when ready rises.
// - Counter reads live; written only while disabled.
// - Counter width is log2 of words.
// - Control bit zero enables capture.
// - Write data port assembles entries while disabled.
// - Memory error makes data ports return error.
// - Mode codes: circular, software, hardware FIFO.
// - Upper registers supply address bits above 32; here they are only stored and read back.
// - Ready only when stopped or disabled and fully drained.
`timescale 1ns/1ps
module trace_ptr_regs (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trace_valid,
  input wire logic [31:0] trace_data,
  input wire logic [6:0] trace_id,
  input wire logic trigger_input_pin,
  input wire logic pipeline_drained,
  input wire logic drain_in_progress,
  input wire logic memory_error_flag,
  output logic trigger_event,
  output logic controller_idle_ready
);
  localparam int AW = trace_pkg::AW;
  localparam int PW = trace_pkg::PTR_W;
  localparam int TW = trace_pkg::TRG_W;
  localparam int EW = trace_pkg::ENTRY_WORDS * 32;
  localparam logic [TW-1:0] TRG_ZERO = trace_pkg::TRG_RST;
  function automatic logic [AW-1:0] entry_of(input logic [PW-1:0] p);
    return p[PW-1:trace_pkg::ENTRY_SHIFT];
  endfunction
  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    return p + PW'(trace_pkg::ENTRY_BYTES);
  endfunction
  trace_pkg::state_e state, next_state;
  trace_pkg::mode_e mode, next_mode;
  logic [PW-1:0] rptr, next_rptr, wptr, next_wptr;
  logic [TW-1:0] post_trigger_word_count, next_trg;
  logic [7:0] rptr_up, next_rptr_up, wptr_up, next_wptr_up;
  logic ctrl_en, next_ctrl_en, full, next_full, triggered, next_triggered;
  logic armed, next_armed, done, next_done;
  logic [1:0] asm_cnt, next_asm_cnt, rd_sel, next_rd_sel;
  logic [EW-33:0] asm_buf, next_asm_buf;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_event, next_ready;
  logic trig_s1, trig_s2, trig_s3, trig_lvl, next_trig_lvl;
  logic setup, wr_acc, rd_acc, ram_we, store, trig_hit, readable, data_port;
  logic [31:0] word;
  logic [EW-1:0] ram_rdata;
  // Three-stage synchroniser for the trigger pin; only stages two and three are compared.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
    end else begin
      trig_s1 <= trigger_input_pin;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
    end
  end
  trace_ram u_ram (
    .mclk(mclk),
    .we(ram_we),
    .waddr(entry_of(wptr)),
    .wdata({word, asm_buf}),
    .raddr(entry_of(next_rptr)),
    .rdata(ram_rdata)
  );
  // Computes bus answers, pointer movement, capture, trigger counting and state.
  always_comb begin
    setup = psel && !penable;
    wr_acc = psel && penable && pready && pwrite;
    rd_acc = psel && penable && pready && !pwrite;
    data_port = (paddr == trace_pkg::OFS_RD_DATA) || (paddr == trace_pkg::OFS_WR_DATA);
    readable = (state == trace_pkg::ST_DISABLED) ||
               (state == trace_pkg::ST_STOPPED && mode == trace_pkg::MODE_CIRC);
    next_state = state;
    next_mode = mode;
    next_rptr = rptr;
    next_wptr = wptr;
    next_trg = post_trigger_word_count;
    next_rptr_up = rptr_up;
    next_wptr_up = wptr_up;
    next_ctrl_en = ctrl_en;
    next_full = full;
    next_triggered = triggered;
    next_armed = armed;
    next_done = done;
    next_asm_cnt = asm_cnt;
    next_asm_buf = asm_buf;
    next_rd_sel = rd_sel;
    next_event = 1'b0;
    next_pready = setup;
    next_pslverr = setup && memory_error_flag && data_port;
    next_prdata = prdata;
    next_trig_lvl = (trig_s2 == trig_s3) ? trig_s3 : trig_lvl;
    trig_hit = (next_trig_lvl && !trig_lvl) ||
               (trace_valid && trace_id == trace_pkg::TRIG_ID);
    store = 1'b0;
    word = trace_data;
    ram_we = 1'b0;
    // Read data is captured in the setup phase so it stands in the access phase.
    if (setup && !pwrite) begin
      next_prdata = 32'h00000000;
      unique case (paddr)
        trace_pkg::OFS_STATUS: begin
          next_prdata[trace_pkg::STS_FULL] = full;
          next_prdata[trace_pkg::STS_TRIGGERED] = triggered;
          next_prdata[trace_pkg::STS_READY] = controller_idle_ready;
          next_prdata[trace_pkg::STS_MEMORY_ERROR_FLAG] = memory_error_flag;
        end
        trace_pkg::OFS_RD_DATA: next_prdata = readable ?
          ram_rdata[rd_sel*32 +: 32] : trace_pkg::NO_DATA;
        trace_pkg::OFS_RPTR: next_prdata[PW-1:0] = rptr;
        trace_pkg::OFS_WPTR: next_prdata[PW-1:0] = wptr;
        trace_pkg::OFS_TRG: next_prdata[TW-1:0] = post_trigger_word_count;
        trace_pkg::OFS_CTRL: next_prdata[trace_pkg::CTRL_EN_BIT] = ctrl_en;
        trace_pkg::OFS_MODE: next_prdata[1:0] = mode;
        trace_pkg::OFS_RPTR_UP: next_prdata[7:0] = rptr_up;
        trace_pkg::OFS_WPTR_UP: next_prdata[7:0] = wptr_up;
        default: next_prdata = 32'h00000000;
      endcase
    end
    // A full entry read through the data port moves the read pointer on.
    if (rd_acc && paddr == trace_pkg::OFS_RD_DATA && readable && !memory_error_flag) begin
      next_rd_sel = rd_sel + 2'h1;
      if (rd_sel == 2'h3) begin
        next_rptr = step(rptr);
      end
    end
    // Register writes; pointer, mode and counter writes are honoured only while disabled.
    if (wr_acc) begin
      unique case (paddr)
        trace_pkg::OFS_CTRL: next_ctrl_en = pwdata[trace_pkg::CTRL_EN_BIT];
        trace_pkg::OFS_RPTR_UP: next_rptr_up = pwdata[7:0];
        trace_pkg::OFS_WPTR_UP: next_wptr_up = pwdata[7:0];
        default: ;
      endcase
      if (state == trace_pkg::ST_DISABLED) begin
        unique case (paddr)
          trace_pkg::OFS_RPTR: begin
            next_rptr = pwdata[PW-1:0];
            next_rd_sel = 2'h0;
          end
          trace_pkg::OFS_WPTR: next_wptr = pwdata[PW-1:0];
          trace_pkg::OFS_TRG: begin
            next_trg = pwdata[TW-1:0];
            next_done = 1'b0;
            next_armed = 1'b0;
          end
          trace_pkg::OFS_MODE: if (pwdata[1:0] != 2'h3) begin
            next_mode = trace_pkg::mode_e'(pwdata[1:0]);
          end
          trace_pkg::OFS_WR_DATA: begin
            word = pwdata;
            store = !memory_error_flag;
          end
          default: ;
        endcase
      end
    end
    // Captured trace words, counted by the trigger logic in circular mode only.
    if (state == trace_pkg::ST_RUNNING) begin
      store = trace_valid;
      if (mode == trace_pkg::MODE_CIRC) begin
        if (armed && trace_valid) begin
          if (post_trigger_word_count == TRG_ZERO) begin
            next_event = 1'b1;
            next_triggered = 1'b1;
            next_armed = 1'b0;
            next_done = 1'b1;
          end else begin
            next_trg = post_trigger_word_count - TW'(1);
          end
        end else if (!armed && !done && trig_hit) begin
          next_armed = 1'b1;
        end
      end
    end
    // Words gather into a full entry, which is stored at the write pointer.
    if (store) begin
      if (asm_cnt == 2'h3) begin
        ram_we = 1'b1;
        next_asm_cnt = 2'h0;
        next_wptr = step(wptr);
        if (&entry_of(wptr)) begin
          next_full = 1'b1;
        end
      end else begin
        next_asm_buf[asm_cnt*32 +: 32] = word;
        next_asm_cnt = asm_cnt + 2'h1;
      end
    end
    // Architectural state sequence driven by the capture enable.
    unique case (state)
      trace_pkg::ST_DISABLED: if (next_ctrl_en) begin
        next_state = trace_pkg::ST_RUNNING;
        next_full = 1'b0;
        next_triggered = 1'b0;
        next_asm_cnt = 2'h0;
        if (mode != trace_pkg::MODE_CIRC) begin
          next_wptr = trace_pkg::PTR_RST;
        end
      end
      trace_pkg::ST_RUNNING: if (!ctrl_en) next_state = trace_pkg::ST_STOPPING;
      trace_pkg::ST_STOPPING: if (pipeline_drained) next_state = trace_pkg::ST_STOPPED;
      trace_pkg::ST_STOPPED: if (!ctrl_en && !drain_in_progress) begin
        next_state = trace_pkg::ST_DISABLED;
        next_rd_sel = 2'h0;
        next_asm_cnt = 2'h0; // A partial entry left by capture is dropped.
        if (mode == trace_pkg::MODE_CIRC) begin
          next_rptr = full ? wptr : trace_pkg::PTR_RST;
        end
      end
    endcase
    next_ready = (next_state == trace_pkg::ST_STOPPED ||
                  next_state == trace_pkg::ST_DISABLED) &&
                 pipeline_drained && !drain_in_progress;
    if (next_ready && !controller_idle_ready) begin
      next_trg = trace_pkg::TRG_RST;
      next_armed = 1'b0;
    end
  end
  // Registers every next value computed above.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= trace_pkg::ST_DISABLED;
      mode <= trace_pkg::MODE_CIRC;
      rptr <= trace_pkg::PTR_RST;
      wptr <= trace_pkg::PTR_RST;
      post_trigger_word_count <= trace_pkg::TRG_RST;
      rptr_up <= 8'h00;
      wptr_up <= 8'h00;
      ctrl_en <= 1'b0;
      full <= 1'b0;
      triggered <= 1'b0;
      armed <= 1'b0;
      done <= 1'b0;
      asm_cnt <= 2'h0;
      asm_buf <= '0;
      rd_sel <= 2'h0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      trigger_event <= 1'b0;
      controller_idle_ready <= 1'b0;
      trig_lvl <= 1'b0;
    end else begin
      state <= next_state;
      mode <= next_mode;
      rptr <= next_rptr;
      wptr <= next_wptr;
      post_trigger_word_count <= next_trg;
      rptr_up <= next_rptr_up;
      wptr_up <= next_wptr_up;
      ctrl_en <= next_ctrl_en;
      full <= next_full;
      triggered <= next_triggered;
      armed <= next_armed;
      done <= next_done;
      asm_cnt <= next_asm_cnt;
      asm_buf <= next_asm_buf;
      rd_sel <= next_rd_sel;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      trigger_event <= next_event;
      controller_idle_ready <= next_ready;
      trig_lvl <= next_trig_lvl;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence run_cleared;
    state == trace_pkg::ST_RUNNING && !ctrl_en;
  endsequence
  sequence entry_read;
    rd_acc && paddr == trace_pkg::OFS_RD_DATA && readable && !memory_error_flag &&
      rd_sel == 2'h3;
  endsequence
  rptr_step_a: assert property (entry_read |=> rptr == step($past(rptr)))
    else $error("read pointer did not advance by one entry");
  wptr_step_a: assert property (ram_we |=> wptr == step($past(wptr)))
    else $error("write pointer did not advance by one entry");
  full_wrap_a: assert property (ram_we && (&entry_of(wptr)) |=> full)
    else $error("wrap did not set full");
  ready_clear_a: assert property ($rose(controller_idle_ready) |-> post_trigger_word_count == TRG_ZERO)
    else $error("counter not cleared on ready");
  fifo_hold_a: assert property (state == trace_pkg::ST_RUNNING &&
    mode != trace_pkg::MODE_CIRC && !next_ready |=> $stable(post_trigger_word_count))
    else $error("counter moved in FIFO mode");
  store_src_a: assert property (ram_we |-> state == trace_pkg::ST_RUNNING ||
    (wr_acc && paddr == trace_pkg::OFS_WR_DATA && state == trace_pkg::ST_DISABLED))
    else $error("entry stored outside capture or disabled write");
  slverr_a: assert property (setup && memory_error_flag &&
    paddr == trace_pkg::OFS_WR_DATA |=> pready && pslverr)
    else $error("no error answer on data port");
  event_zero_a: assert property (trigger_event |-> post_trigger_word_count == TRG_ZERO && done)
    else $error("trigger event without zero count");
  leave_home_a: assert property (state == trace_pkg::ST_DISABLED && next_ctrl_en &&
    mode != trace_pkg::MODE_CIRC |=> wptr == trace_pkg::PTR_RST)
    else $error("write pointer not returned home");
  stop_path_a: assert property (run_cleared |=> state == trace_pkg::ST_STOPPING)
    else $error("clearing enable did not begin stopping");
  ready_state_a: assert property (controller_idle_ready |-> state == trace_pkg::ST_STOPPED ||
    state == trace_pkg::ST_DISABLED)
    else $error("ready outside stopped or disabled");
endmodule

// *** verification/apb_sw_model.sv ***
// Debug software model that issues single APB transfers to the pointer bank.
// Assumes a bank that raises pready within a few cycles of the access phase.
`timescale 1ns/1ps
module apb_sw_model (
  input wire logic mclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  logic capturing;

  // The bus starts idle with capture believed off.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    capturing = 1'b0;
  end

  // Unless it is a pointer or counter write while capture is believed on, runs one setup and access phase, then parks the lines on inverted values.
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err, output logic tout);
    int n;
    logic [31:0] dd;
    dd = d;
    rd = 32'h0;
    err = 1'b0;
    tout = 1'b0;
    if (wr && (a == trace_pkg::OFS_RPTR || a == trace_pkg::OFS_WPTR)) begin
      dd = {d[31:4], 4'h0};
    end
    if (wr && capturing && (a == trace_pkg::OFS_RPTR || a == trace_pkg::OFS_WPTR ||
        a == trace_pkg::OFS_TRG)) begin
      return;
    end
    if (wr && a == trace_pkg::OFS_CTRL) begin
      capturing = d[0];
    end
    @(negedge mclk);
    psel = 1'b1;
    penable = 1'b0;
    pwrite = wr;
    paddr = a;
    pwdata = dd;
    @(negedge mclk);
    penable = 1'b1;
    n = 0;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 8) begin
      n++;
      @(posedge mclk);
    end
    tout = (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    @(negedge mclk);
    psel = 1'b0;
    penable = 1'b0;
    paddr = ~a;
    pwdata = ~dd;
  endtask
endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the trace pointer register bank.
// Assumes the software model above drives the APB port; trace inputs come from here.
`timescale 1ns/1ps
module testbench;
  logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, trace_valid, pin;
  logic memory_error_flag, trigger_event, controller_idle_ready, drained, draining;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, trace_data, seq, ev_cnt, ev0;
  logic [6:0] trace_id;
  int num_errors, samples_checked;

  trace_ptr_regs trace_ptr_regs_inst (.mclk(mclk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trace_valid(trace_valid), .trace_data(trace_data),
    .trace_id(trace_id), .trigger_input_pin(pin), .pipeline_drained(drained),
    .drain_in_progress(draining), .memory_error_flag(memory_error_flag),
    .trigger_event(trigger_event), .controller_idle_ready(controller_idle_ready));

  apb_sw_model apb_sw_model_inst (.mclk(mclk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));

  // Free-running 200 MHz clock.
  always #2.5 mclk = ~mclk;

  // Counts trigger event pulses.
  always @(posedge mclk) begin
    if (trigger_event === 1'b1) ev_cnt <= ev_cnt + 32'h1;
  end

  // Compares one value and reports a difference.
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // A wait that ran out counts as a mismatch.
  task automatic timed_out();
    num_errors++;
    print_verdict();
  endtask

  // Register write through the software model.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic e, t;
    apb_sw_model_inst.xfer(1'b1, a, d, rd, e, t);
    if (t) timed_out();
  endtask

  // Register read compared under a mask.
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp,
                       input logic [31:0] m = 32'hffffffff);
    logic [31:0] rd;
    logic e, t;
    apb_sw_model_inst.xfer(1'b0, a, 32'h0, rd, e, t);
    if (t) timed_out();
    check(nm, rd & m, exp);
  endtask

  // Transfer whose error response is compared.
  task automatic errchk(input string nm, input logic w, input logic [11:0] a, input logic x);
    logic [31:0] rd;
    logic e, t;
    apb_sw_model_inst.xfer(w, a, 32'h0, rd, e, t);
    if (t) timed_out();
    check(nm, {31'h0, e}, {31'h0, x});
  endtask

  // Sends n trace words back to back, the first one with source id id0.
  task automatic words(input int n, input logic [6:0] id0);
    for (int i = 0; i < n; i++) begin
      @(negedge mclk);
      trace_valid = 1'b1;
      trace_data = 32'h00c00000 + seq;
      trace_id = (i == 0) ? id0 : 7'h00;
      seq = seq + 32'h1;
    end
    @(negedge mclk);
    trace_valid = 1'b0;
  endtask

  // Clears the enable and polls until the ready bit is set.
  task automatic stop_wait();
    logic [31:0] rd;
    logic e, t;
    int n;
    wr(trace_pkg::OFS_CTRL, 32'h0);
    n = 0;
    rd = 32'h0;
    while (rd[trace_pkg::STS_READY] !== 1'b1) begin
      if (n == 30) timed_out();
      n++;
      apb_sw_model_inst.xfer(1'b0, trace_pkg::OFS_STATUS, 32'h0, rd, e, t);
    end
  endtask

  // Reset values, ready after reset and an unmapped read.
  task automatic sc_reset();
    rdchk("rptr", trace_pkg::OFS_RPTR, 32'h0);
    rdchk("wptr", trace_pkg::OFS_WPTR, 32'h0);
    rdchk("trg", trace_pkg::OFS_TRG, 32'h0);
    rdchk("ctrl", trace_pkg::OFS_CTRL, 32'h0);
    rdchk("ready", trace_pkg::OFS_STATUS, 32'h4, 32'h7);
    rdchk("unmapped", 12'h100, 32'h0);
    wr(trace_pkg::OFS_CTRL, 32'hfffffffe);
    rdchk("ctrl rsvd", trace_pkg::OFS_CTRL, 32'h0);
    wr(trace_pkg::OFS_RPTR_UP, 32'h5a);
    rdchk("rptr up", trace_pkg::OFS_RPTR_UP, 32'h5a);
    wr(trace_pkg::OFS_WPTR_UP, 32'ha5);
    rdchk("wptr up", trace_pkg::OFS_WPTR_UP, 32'ha5);
  endtask

  // Entry assembly through the write port and read back through the read port.
  task automatic sc_wrdata();
    wr(trace_pkg::OFS_WPTR, 32'h20);
    for (int i = 0; i < 4; i++) begin
      wr(trace_pkg::OFS_WR_DATA, 32'h5a000000 + i);
      if (i == 2) rdchk("wptr part", trace_pkg::OFS_WPTR, 32'h20);
    end
    rdchk("wptr step", trace_pkg::OFS_WPTR, 32'h30);
    wr(trace_pkg::OFS_RPTR, 32'h20);
    for (int i = 0; i < 4; i++) rdchk("rd word", trace_pkg::OFS_RD_DATA, 32'h5a000000 + i);
    rdchk("rptr step", trace_pkg::OFS_RPTR, 32'h30);
  endtask

  // Circular capture from a programmed pointer across the top of memory.
  task automatic sc_circ();
    seq = 32'h0;
    wr(trace_pkg::OFS_WPTR, 32'h3f0);
    wr(trace_pkg::OFS_CTRL, 32'h1);
    rdchk("ready run", trace_pkg::OFS_STATUS, 32'h0, 32'h4);
    wr(trace_pkg::OFS_WR_DATA, 32'hdead0000);
    rdchk("wptr ignore", trace_pkg::OFS_WPTR, 32'h3f0);
    words(8, 7'h00);
    rdchk("wptr wrap", trace_pkg::OFS_WPTR, 32'h10);
    rdchk("full", trace_pkg::OFS_STATUS, 32'h1, 32'h1);
    stop_wait();
    rdchk("rptr oldest", trace_pkg::OFS_RPTR, 32'h10);
    wr(trace_pkg::OFS_RPTR, 32'h3f0);
    for (int i = 0; i < 8; i++) begin
      rdchk("trace word", trace_pkg::OFS_RD_DATA, 32'h00c00000 + i);
      if (i == 3) rdchk("rptr wrap", trace_pkg::OFS_RPTR, 32'h0);
    end
  endtask

  // Post-trigger counting from a trace packet and from the pin.
  task automatic sc_trig();
    ev0 = ev_cnt;
    wr(trace_pkg::OFS_TRG, 32'h3);
    wr(trace_pkg::OFS_CTRL, 32'h1);
    rdchk("trg live", trace_pkg::OFS_TRG, 32'h3);
    words(4, trace_pkg::TRIG_ID);
    repeat (3) @(negedge mclk);
    check("early event", ev_cnt, ev0);
    words(1, 7'h00);
    repeat (2) @(negedge mclk);
    check("event", ev_cnt, ev0 + 32'h1);
    rdchk("triggered", trace_pkg::OFS_STATUS, 32'h2, 32'h2);
    words(9, trace_pkg::TRIG_ID);
    repeat (2) @(negedge mclk);
    check("retrigger", ev_cnt, ev0 + 32'h1);
    rdchk("trg hold", trace_pkg::OFS_TRG, 32'h0);
    stop_wait();
    wr(trace_pkg::OFS_TRG, 32'h1);
    wr(trace_pkg::OFS_CTRL, 32'h1);
    @(negedge mclk);
    pin = 1'b1;
    repeat (6) @(negedge mclk);
    pin = 1'b0;
    words(1, 7'h00);
    repeat (3) @(negedge mclk);
    check("pin early", ev_cnt, ev0 + 32'h1);
    words(1, 7'h00);
    repeat (2) @(negedge mclk);
    check("pin event", ev_cnt, ev0 + 32'h2);
    stop_wait();
    wr(trace_pkg::OFS_TRG, 32'h5);
    wr(trace_pkg::OFS_CTRL, 32'h1);
    drained = 1'b0;
    draining = 1'b1;
    wr(trace_pkg::OFS_CTRL, 32'h0);
    repeat (4) @(negedge mclk);
    rdchk("ready undrained", trace_pkg::OFS_STATUS, 32'h0, 32'h4);
    drained = 1'b1;
    repeat (4) @(negedge mclk);
    check("ready pin low", {31'h0, controller_idle_ready}, 32'h0);
    rdchk("trg kept", trace_pkg::OFS_TRG, 32'h5);
    draining = 1'b0;
    stop_wait();
    check("ready pin high", {31'h0, controller_idle_ready}, 32'h1);
    rdchk("trg cleared", trace_pkg::OFS_TRG, 32'h0);
  endtask

  // Both FIFO modes ignore the counter and restart the write pointer.
  task automatic sc_fifo();
    for (int m = 1; m < 3; m++) begin
      ev0 = ev_cnt;
      wr(trace_pkg::OFS_MODE, m);
      rdchk("mode", trace_pkg::OFS_MODE, m, 32'h3);
      wr(trace_pkg::OFS_WPTR, 32'h100);
      wr(trace_pkg::OFS_TRG, 32'h1);
      wr(trace_pkg::OFS_CTRL, 32'h1);
      words(6, trace_pkg::TRIG_ID);
      repeat (3) @(negedge mclk);
      check("fifo event", ev_cnt, ev0);
      rdchk("wptr home", trace_pkg::OFS_WPTR, 32'h10);
      stop_wait();
    end
    wr(trace_pkg::OFS_MODE, 32'h3);
    rdchk("mode kept", trace_pkg::OFS_MODE, 32'h2, 32'h3);
    wr(trace_pkg::OFS_MODE, 32'h0);
  endtask

  // Memory error answers the data ports with an error and discards writes.
  task automatic sc_memory_error_flag();
    wr(trace_pkg::OFS_WPTR, 32'h40);
    @(negedge mclk);
    memory_error_flag = 1'b1;
    for (int i = 0; i < 4; i++) errchk("wr err", 1'b1, trace_pkg::OFS_WR_DATA, 1'b1);
    errchk("rd err", 1'b0, trace_pkg::OFS_RD_DATA, 1'b1);
    errchk("ptr ok", 1'b0, trace_pkg::OFS_RPTR, 1'b0);
    @(negedge mclk);
    memory_error_flag = 1'b0;
    rdchk("wptr kept", trace_pkg::OFS_WPTR, 32'h40);
    repeat (3) wr(trace_pkg::OFS_WR_DATA, 32'h0);
    rdchk("wptr three words", trace_pkg::OFS_WPTR, 32'h40);
    wr(trace_pkg::OFS_WR_DATA, 32'h0);
    rdchk("wptr entry", trace_pkg::OFS_WPTR, 32'h50);
  endtask

  // Main sequence: reset for five cycles, then every scenario in turn.
  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    trace_valid = 1'b0;
    trace_data = 32'h0;
    trace_id = 7'h00;
    pin = 1'b0;
    memory_error_flag = 1'b0;
    drained = 1'b1;
    draining = 1'b0;
    seq = 32'h0;
    ev_cnt = 32'h0;
    num_errors = 0;
    samples_checked = 0;
    repeat (5) @(negedge mclk);
    rst_b = 1'b1;
    sc_reset();
    sc_wrdata();
    sc_circ();
    sc_trig();
    sc_fifo();
    sc_memory_error_flag();
    print_verdict();
  end
endmodule
